// File: hdl/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_CONTROL_WORD_A   = 2'h0;
  localparam logic [1:0] IDX_STATUS  = 2'h1;
  localparam logic [1:0] IDX_INTSTAT = 2'h2;
  localparam logic [1:0] IDX_INTMASK = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PERIOD_LSB = 0;
  localparam int         WINDOW_LSB = 4;
  localparam int         LOCK_BIT   = 7;
  localparam int         SYNC_BIT   = 0;
  localparam int         EV_TIMEOUT = 0;
  localparam int         EV_EARLY   = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] EV_RESET   = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         OSC_RATE_HZ = 1000;
  localparam logic [1:0] SYNC_TICKS  = 2'h2;
  localparam logic [3:0] MAX_CODE    = 4'hB;
  localparam logic [3:0] CODE_SHIFT  = 4'h2;
  localparam int         CNT_W       = 14;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_OPEN   = 3'b010,
    ST_CLOSED = 3'b100
  } wd_state_t;

endpackage

// File: hdl/window_watchdog_timer.sv
module window_watchdog_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        watchdogOscClock,
  input  wire logic        watchdogClearInstruction,
  input  wire logic        changeProtectionUnlock,
  input  wire logic        debugHalt,
  input  wire logic [7:0]  fuseWatchdogConfig,
  output logic             systemReset,
  output logic             irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic codeValid(input logic [3:0] c);
    codeValid = (c != 4'h0) && (c <= wdt_pkg::MAX_CODE);
  endfunction
  function automatic logic [wdt_pkg::CNT_W-1:0] lastCount(input logic [3:0] c);
    lastCount = (14'h0001 << (c + wdt_pkg::CODE_SHIFT)) - 14'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Oscillator clock synchroniser
  // ----------------------------------------------------------------
  logic oscMeta_reg;
  logic oscSync_reg;
  logic oscPrev_reg;
  logic oscTick;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oscMeta_reg <= 1'b0;
      oscSync_reg <= 1'b0;
      oscPrev_reg <= 1'b0;
    end else begin
      oscMeta_reg <= watchdogOscClock;
      oscSync_reg <= oscMeta_reg;
      oscPrev_reg <= oscSync_reg;
    end
  end
  // One tick per rising edge of the 1 kHz clock; no sleep gating
  assign oscTick = oscSync_reg & ~oscPrev_reg;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wrPend_reg;
  logic        wrPend_next;
  logic [1:0]  wrIdx_reg;
  logic [1:0]  wrIdx_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        addrPhase;
  logic        mapped;
  logic [7:0] ctrlShadow_reg;
  logic [7:0] activeCtrl_reg;
  logic       lock_reg;
  logic       sync_pending_reg;
  logic [1:0] intStat_reg;
  logic [1:0] intMask_reg;
  assign addrPhase = hsel & htrans[1] & hready;
  assign mapped    = (haddr[31:4] == 28'h0000000);
  always_comb begin
    wrPend_next = 1'b0;
    wrIdx_next  = wrIdx_reg;
    rdata_next  = 32'h00000000;
    if (addrPhase) begin
      wrPend_next = hwrite & mapped;
      wrIdx_next  = haddr[3:2];
      if (!hwrite && mapped) begin
        case (haddr[3:2])
          wdt_pkg::IDX_CONTROL_WORD_A:   rdata_next = {24'h000000, ctrlShadow_reg};
          wdt_pkg::IDX_STATUS:  rdata_next = {24'h000000, lock_reg, 6'h00, sync_pending_reg};
          wdt_pkg::IDX_INTSTAT: rdata_next = {30'h0, intStat_reg};
          wdt_pkg::IDX_INTMASK: rdata_next = {30'h0, intMask_reg};
          default:              rdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 2'h0;
      rdata_reg  <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wrPend_reg <= wrPend_next;
      wrIdx_reg  <= wrIdx_next;
      rdata_reg  <= rdata_next;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  assign hrdata = rdata_reg;
  // ----------------------------------------------------------------
  // Configuration, lock and interrupt registers
  // ----------------------------------------------------------------
  logic       booted_reg;
  logic [1:0] syncCnt_reg;
  logic [7:0] ctrlShadow_next;
  logic [7:0] activeCtrl_next;
  logic       lock_next;
  logic       sync_pending_next;
  logic [1:0] syncCnt_next;
  logic [1:0] intStat_next;
  logic [1:0] intMask_next;
  logic [1:0] w1c;
  logic [1:0] events;
  logic       cfgApply;
  logic       ctrlWrite;
  assign cfgApply  = sync_pending_reg & oscTick & (syncCnt_reg == wdt_pkg::SYNC_TICKS - 2'h1);
  assign ctrlWrite = wrPend_reg & (wrIdx_reg == wdt_pkg::IDX_CONTROL_WORD_A);
  always_comb begin
    ctrlShadow_next = ctrlShadow_reg;
    activeCtrl_next = activeCtrl_reg;
    lock_next       = lock_reg;
    sync_pending_next   = sync_pending_reg;
    syncCnt_next    = syncCnt_reg;
    intMask_next    = intMask_reg;
    w1c             = 2'h0;
    if (!booted_reg) begin
      ctrlShadow_next = fuseWatchdogConfig;
      activeCtrl_next = fuseWatchdogConfig;
      lock_next       = codeValid(fuseWatchdogConfig[wdt_pkg::PERIOD_LSB +: 4]);
    end else begin
      if (sync_pending_reg && oscTick) begin
        syncCnt_next = syncCnt_reg + 2'h1;
        if (cfgApply) begin
          sync_pending_next   = 1'b0;
          activeCtrl_next = ctrlShadow_reg;
        end
      end
      if (wrPend_reg) begin
        case (wrIdx_reg)
          wdt_pkg::IDX_CONTROL_WORD_A: begin
            if (changeProtectionUnlock && !lock_reg && !sync_pending_reg) begin
              ctrlShadow_next = hwdata[7:0];
              sync_pending_next   = 1'b1;
              syncCnt_next    = 2'h0;
            end
          end
          wdt_pkg::IDX_STATUS: begin
            if (changeProtectionUnlock) begin
              if (hwdata[wdt_pkg::LOCK_BIT]) begin
                lock_next = 1'b1;
              end else if (debugHalt) begin
                lock_next = 1'b0;
              end
            end
          end
          wdt_pkg::IDX_INTSTAT: w1c = hwdata[1:0];
          wdt_pkg::IDX_INTMASK: intMask_next = hwdata[1:0];
          default: w1c = 2'h0;
        endcase
      end
    end
    // A new event wins over a simultaneous clear
    intStat_next = (intStat_reg & ~w1c) | events;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      booted_reg     <= 1'b0;
      ctrlShadow_reg <= wdt_pkg::CTRL_RESET;
      activeCtrl_reg <= wdt_pkg::CTRL_RESET;
      lock_reg       <= 1'b0;
      sync_pending_reg   <= 1'b0;
      syncCnt_reg    <= 2'h0;
      intStat_reg    <= wdt_pkg::EV_RESET;
      intMask_reg    <= wdt_pkg::EV_RESET;
    end else begin
      booted_reg     <= 1'b1;
      ctrlShadow_reg <= ctrlShadow_next;
      activeCtrl_reg <= activeCtrl_next;
      lock_reg       <= lock_next;
      sync_pending_reg   <= sync_pending_next;
      syncCnt_reg    <= syncCnt_next;
      intStat_reg    <= intStat_next;
      intMask_reg    <= intMask_next;
    end
  end
  // ----------------------------------------------------------------
  // Watchdog counter and window sequencer
  // ----------------------------------------------------------------
  wdt_pkg::wd_state_t        state_reg;
  wdt_pkg::wd_state_t        state_next;
  logic [wdt_pkg::CNT_W-1:0] cnt_reg;
  logic [wdt_pkg::CNT_W-1:0] cnt_next;
  logic                      clrBusy_reg;
  logic                      clrBusy_next;
  logic [1:0]                clrCnt_reg;
  logic [1:0]                clrCnt_next;
  logic                      sysRst_next;
  logic                      irq_next;
  logic                      clrDone;
  logic                      enabled;
  logic                      winMode;
  logic [3:0]                perCode;
  logic [3:0]                winCode;
  logic                      evTimeout;
  logic                      evEarly;
  assign perCode = activeCtrl_reg[wdt_pkg::PERIOD_LSB +: 4];
  assign winCode = activeCtrl_reg[wdt_pkg::WINDOW_LSB +: 4];
  assign enabled = codeValid(perCode);
  assign winMode = enabled & codeValid(winCode);
  assign clrDone = clrBusy_reg & oscTick & (clrCnt_reg == wdt_pkg::SYNC_TICKS - 2'h1);
  assign events  = {evEarly, evTimeout};
  always_comb begin
    clrBusy_next = clrBusy_reg;
    clrCnt_next  = clrCnt_reg;
    if (clrBusy_reg) begin
      if (oscTick) begin
        clrCnt_next = clrCnt_reg + 2'h1;
      end
      if (clrDone) begin
        clrBusy_next = 1'b0;
      end
    end else if (watchdogClearInstruction) begin
      clrBusy_next = 1'b1;
      clrCnt_next  = 2'h0;
    end
  end
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    evTimeout  = 1'b0;
    evEarly    = 1'b0;
    if (!enabled) begin
      state_next = wdt_pkg::ST_IDLE;
      cnt_next   = '0;
    end else if (debugHalt) begin
      state_next = wdt_pkg::ST_OPEN;
      cnt_next   = '0;
    end else if (cfgApply || state_reg == wdt_pkg::ST_IDLE) begin
      // Closed timing waits for the first clear
      state_next = wdt_pkg::ST_OPEN;
      cnt_next   = '0;
    end else begin
      case (state_reg)
        wdt_pkg::ST_OPEN: begin
          if (clrDone) begin
            cnt_next   = '0;
            state_next = winMode ? wdt_pkg::ST_CLOSED : wdt_pkg::ST_OPEN;
          end else if (oscTick) begin
            if (cnt_reg == lastCount(perCode)) begin
              evTimeout = 1'b1;
              cnt_next  = '0;
            end else begin
              cnt_next = cnt_reg + 14'h0001;
            end
          end
        end
        wdt_pkg::ST_CLOSED: begin
          if (clrDone) begin
            evEarly    = 1'b1;
            cnt_next   = '0;
            state_next = wdt_pkg::ST_OPEN;
          end else if (oscTick) begin
            if (cnt_reg == lastCount(winCode)) begin
              cnt_next   = '0;
              state_next = wdt_pkg::ST_OPEN;
            end else begin
              cnt_next = cnt_reg + 14'h0001;
            end
          end
        end
        default: begin
          state_next = wdt_pkg::ST_IDLE;
          cnt_next   = '0;
        end
      endcase
    end
    sysRst_next = evTimeout | evEarly;
    irq_next    = |(intStat_next & intMask_next);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg   <= wdt_pkg::ST_IDLE;
      cnt_reg     <= '0;
      clrBusy_reg <= 1'b0;
      clrCnt_reg  <= 2'h0;
      systemReset <= 1'b0;
      irq         <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      clrBusy_reg <= clrBusy_next;
      clrCnt_reg  <= clrCnt_next;
      systemReset <= sysRst_next;
      irq         <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_timeout_reset: assert property (
    state_reg == wdt_pkg::ST_OPEN && enabled && !debugHalt && !cfgApply && !clrDone &&
    oscTick && cnt_reg == lastCount(perCode) |=> systemReset && cnt_reg == '0)
    else $error("time-out did not reset the system");
  a_early_clear: assert property (
    state_reg == wdt_pkg::ST_CLOSED && enabled && !debugHalt && !cfgApply && clrDone
    |=> systemReset && state_reg == wdt_pkg::ST_OPEN)
    else $error("early clear did not reset the system");
  a_unlock_needed: assert property (
    booted_reg && ctrlWrite && !changeProtectionUnlock |=> $stable(ctrlShadow_reg))
    else $error("unprotected control write took effect");
  a_lock_freezes: assert property (
    booted_reg && lock_reg |=> $stable(ctrlShadow_reg))
    else $error("locked control register changed");
  a_lock_sticky: assert property (
    booted_reg && lock_reg && !debugHalt |=> lock_reg)
    else $error("lock cleared outside debug");
  a_sync_refuse: assert property (
    booted_reg && ctrlWrite && sync_pending_reg |=> $stable(ctrlShadow_reg))
    else $error("control write accepted while sync pending");
  a_sync_tick: assert property (
    booted_reg && $past(booted_reg) && $changed(activeCtrl_reg) |-> $past(oscTick))
    else $error("active control changed without oscillator tick");
  a_halt_clears: assert property (
    enabled && debugHalt |=> cnt_reg == '0 && state_reg == wdt_pkg::ST_OPEN)
    else $error("debug halt did not clear the counter");
  a_clear_ignored: assert property (
    clrBusy_reg && !oscTick |=> clrBusy_reg && $stable(clrCnt_reg))
    else $error("clear during synchronisation restarted it");
  a_disabled_idle: assert property (
    booted_reg && !enabled |=> state_reg == wdt_pkg::ST_IDLE && !systemReset)
    else $error("disabled watchdog is running");
  c_timeout: cover property (state_reg == wdt_pkg::ST_OPEN ##1 systemReset);
  c_early: cover property (state_reg == wdt_pkg::ST_CLOSED ##1 systemReset);
  c_window: cover property (state_reg == wdt_pkg::ST_CLOSED ##1 state_reg == wdt_pkg::ST_OPEN);
  c_lock: cover property (!lock_reg ##1 lock_reg);

endmodule

// File: verif/cpu_core_model.sv
module cpu_core_model (
  input  wire logic core_clk,
  output logic      watchdogClearInstruction,
  output logic      changeProtectionUnlock
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Core side: clear pulses and the protected-write unlock level
  // ------------------------------------------------------------
  initial begin
    watchdogClearInstruction = 1'b0;
    changeProtectionUnlock   = 1'b0;
  end

  // One clear instruction: a single-cycle pulse launched after an edge
  task automatic clear_now();
    @(posedge core_clk);
    watchdogClearInstruction <= 1'b1;
    @(posedge core_clk);
    watchdogClearInstruction <= 1'b0;
  endtask

  // Unlock stays up through the following protected write
  task automatic set_unlock(input logic on);
    changeProtectionUnlock <= on;
  endtask
endmodule

// File: verif/test_window_watchdog_timer.sv
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module test_window_watchdog_timer;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wr;
    logic        unl;
    logic [7:0]  exp;
  } row_t;

  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        watchdogOscClock;
  logic        watchdogClearInstruction;
  logic        changeProtectionUnlock;
  logic        debugHalt;
  logic [7:0]  fuseWatchdogConfig;
  logic        systemReset;
  logic        irq;
  logic [31:0] q;
  int          fail_count = 0;
  int          checks_done = 0;
  int          tickCount = 0;
  int          t;
  row_t        rows [6] = '{'{32'h0, 8'h2B, 1'b1, 8'h2B}, '{32'h0, 8'h33, 1'b0, 8'h2B},
                            '{32'hC, 8'h03, 1'b1, 8'h03}, '{32'h10, 8'hFF, 1'b1, 8'h00},
                            '{32'hC, 8'h00, 1'b1, 8'h00}, '{32'h0, 8'h00, 1'b1, 8'h00}};

  assign hready = hreadyout;

  window_watchdog_timer u_window_watchdog_timer (.core_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .watchdogOscClock,
    .watchdogClearInstruction, .changeProtectionUnlock, .debugHalt, .fuseWatchdogConfig,
    .systemReset, .irq);

  cpu_core_model u_cpu_core_model (.core_clk, .watchdogClearInstruction,
    .changeProtectionUnlock);

  // ------------------------------------------------------------
  // Clocks: 40 MHz core, fast unrelated watchdog oscillator
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    watchdogOscClock = 1'b0;
    #37;
    forever #100 watchdogOscClock = ~watchdogOscClock;
  end

  always @(posedge watchdogOscClock) tickCount <= tickCount + 1;

  // ------------------------------------------------------------
  // Bus, wait and check tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic give_up(input string nm);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", nm);
    report_and_stop();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) give_up("hready");
      @(posedge core_clk);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    // Address phase ends at the edge where hready is seen high
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    // Data phase ends likewise; read data is taken at that edge
    wait_ready();
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic unl);
    u_cpu_core_model.set_unlock(unl);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm);
    bus(a, 1'b0, 8'h00);
    `CHK(nm, {24'h0, e}, q)
  endtask

  task automatic wait_sync();
    int n;
    n = 0;
    bus(32'h4, 1'b0, 8'h00);
    while (q[0] !== 1'b0) begin
      n++;
      if (n > 40) give_up("sync");
      bus(32'h4, 1'b0, 8'h00);
    end
  endtask

  // Watch about lim oscillator ticks; t is the tick count to the reset pulse or -1
  task automatic wait_rst(input int lim);
    int t0;
    int n;
    t0 = tickCount;
    t = -1;
    n = 0;
    while (t < 0 && n < lim * 8) begin
      @(negedge core_clk);
      n++;
      if (systemReset === 1'b1) t = tickCount - t0;
    end
    @(posedge core_clk);
  endtask

  // Oscillator phase and synchronisers blur the count by a few ticks
  task automatic check_ticks(input string nm, input int e);
    `CHK(nm, e, (t >= e - 3 && t <= e + 3) ? e : t)
  endtask

  task automatic do_reset(input logic [7:0] f);
    rst_n <= 1'b0;
    fuseWatchdogConfig <= f;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    debugHalt = 1'b0;
    fuseWatchdogConfig = 8'h00;
    do_reset(8'h00);
    `CHK("irq at reset", 1'b0, irq)
    rd(32'h0, 8'h00, "ctrl from zero fuse");
    rd(32'h4, 8'h00, "status reset");
    rd(32'h8, 8'h00, "intstat reset");
    $display("test reset finished");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wr, rows[i].unl);
      wait_sync();
      rd(rows[i].addr, rows[i].exp, "table row");
    end
    $display("test table finished");
    wr(32'h0, 8'h01, 1'b1);
    rd(32'h4, 8'h01, "sync pending");
    wr(32'h0, 8'h05, 1'b1);
    wait_sync();
    rd(32'h0, 8'h01, "write while pending");
    wr(32'h8, 8'h03, 1'b1);
    wr(32'hC, 8'h01, 1'b1);
    $display("test sync finished");
    for (int k = 1; k <= 4; k++) begin
      wr(32'h0, 8'(k), 1'b1);
      wait_sync();
      wait_rst((1 << (k + 2)) + 8);
      check_ticks("period ticks", 1 << (k + 2));
    end
    `CHK("irq on timeout", 1'b1, irq)
    rd(32'h8, 8'h01, "timeout event");
    wr(32'h8, 8'h01, 1'b1);
    rd(32'h8, 8'h00, "event cleared");
    `CHK("irq cleared", 1'b0, irq)
    wr(32'h0, 8'h0C, 1'b1);
    wait_sync();
    wait_rst(80);
    `CHK("reserved period", -1, t)
    wr(32'h0, 8'h02, 1'b1);
    wait_sync();
    repeat (5) begin
      u_cpu_core_model.clear_now();
      wait_rst(7);
      `CHK("cleared in time", -1, t)
    end
    $display("test normal mode finished");
    wr(32'h8, 8'h03, 1'b1);
    wr(32'h0, 8'h11, 1'b1);
    wait_sync();
    u_cpu_core_model.clear_now();
    wait_rst(4);
    `CHK("closed quiet", -1, t)
    u_cpu_core_model.clear_now();
    wait_rst(6);
    `CHK("early clear", 1'b1, t >= 0)
    rd(32'h8, 8'h02, "early event");
    `CHK("masked event", 1'b0, irq)
    u_cpu_core_model.clear_now();
    wait_rst(26);
    check_ticks("closed plus open", 18);
    u_cpu_core_model.clear_now();
    repeat (8) @(posedge core_clk);
    u_cpu_core_model.clear_now();
    wait_rst(12);
    `CHK("second clear ignored", -1, t)
    u_cpu_core_model.clear_now();
    wait_rst(4);
    `CHK("clear in open", -1, t)
    $display("test window mode finished");
    debugHalt <= 1'b1;
    wait_rst(40);
    `CHK("halted", -1, t)
    debugHalt <= 1'b0;
    wait_rst(16);
    check_ticks("resume period", 8);
    $display("test debug finished");
    wr(32'h4, 8'h80, 1'b1);
    wr(32'h0, 8'h00, 1'b1);
    rd(32'h0, 8'h11, "locked ctrl");
    wr(32'h4, 8'h00, 1'b1);
    rd(32'h4, 8'h80, "lock stays");
    debugHalt <= 1'b1;
    wr(32'h4, 8'h00, 1'b1);
    rd(32'h4, 8'h00, "lock cleared in halt");
    wr(32'h4, 8'h80, 1'b0);
    rd(32'h4, 8'h00, "lock without unlock");
    debugHalt <= 1'b0;
    $display("test lock finished");
    do_reset(8'h21);
    rd(32'h0, 8'h21, "ctrl from fuse");
    rd(32'h4, 8'h80, "lock from fuse");
    rd(32'hC, 8'h00, "mask reset");
    wait_rst(14);
    check_ticks("fuse period", 8);
    $display("test boot finished");
    report_and_stop();
  end
endmodule
